// *** mcu_move_logic_return_ops_tb_top.sv ***
// Self-checking testbench of the move, logic and return unit.
`default_nettype none
module mcu_move_logic_return_ops_tb_top;
  timeunit 1ns / 1ps;
  import mlr_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       instr_valid = 1'b0;
  logic       irq_taken = 1'b0;
  mlr_instr_t instr = 12'h000;
  mlr_pc_t    stack_top = 11'h000;
  mlr_data_t  fr [32];
  int         failures = 0;
  int         total_checks = 0;
  logic       instr_ready, file_we, zero_flag, global_irq_enable, pc_load, stack_pop, pc_advance, retire, illegal_op;
  mlr_faddr_t file_raddr, file_waddr;
  mlr_data_t  file_rdata, file_wdata, accum, option_reg;
  mlr_bank_t  bank_select_reg;
  mlr_pc_t    pc_value;
  always #4 clk = ~clk;
  // The file register model answers in the same cycle, as the unit expects.
  assign file_rdata = fr[file_raddr];
  always @(posedge clk) if (file_we) fr[file_waddr] <= file_wdata;
  mlr_exec dut (
    .clk, .rst_n, .instr_valid, .instr_ready, .instr, .file_raddr, .file_rdata, .stack_top, .irq_taken,
    .file_we, .file_waddr, .file_wdata, .accum, .zero_flag, .bank_select_reg, .option_reg,
    .global_irq_enable, .pc_load, .pc_value, .stack_pop, .pc_advance, .retire, .illegal_op
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic issue(input mlr_instr_t w);
    int n;
    n = 0;
    @(negedge clk);
    instr_valid = 1'b1;
    instr = w;
    while (instr_ready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask
  task automatic run(input mlr_instr_t w);
    issue(w);
    @(negedge clk);
    instr_valid = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_or_lit();
    fr[3] = 8'h50;
    run(12'hC0A);
    chk(accum, 8'h0A);
    run(12'h103);
    chk({file_we, zero_flag, accum}, {2'b00, 8'h5A});
    run(12'hC00);
    run(12'h124);
    chk({file_we, file_waddr, file_wdata, zero_flag, accum}, {1'b1, 5'h04, 8'h00, 1'b1, 8'h00});
    run(12'hCA5);
    chk({zero_flag, accum}, {1'b1, 8'hA5});
    $display("Test or and literal done");
  endtask
  task automatic t_store_copy();
    run(12'h03F);
    chk({file_we, file_waddr, file_wdata, zero_flag}, {1'b1, 5'h1F, 8'hA5, 1'b1});
    issue(12'hC00);
    issue(12'h21F);
    @(negedge clk);
    instr_valid = 1'b0;
    chk({file_we, zero_flag, accum}, {2'b00, 8'hA5});
    run(12'h224);
    chk({file_we, file_wdata, zero_flag, accum}, {1'b1, 8'h00, 1'b1, 8'hA5});
    $display("Test store and copy done");
  endtask
  task automatic t_bank_option_idle();
    run(12'h017);
    chk({bank_select_reg, zero_flag}, {3'h7, 1'b1});
    run(12'hC3C);
    run(12'h002);
    chk({option_reg, zero_flag}, {8'h3C, 1'b1});
    run(12'h000);
    chk({pc_advance, retire, file_we, pc_load, accum}, {4'b1100, 8'h3C});
    $display("Test bank, option and idle done");
  endtask
  task automatic t_returns();
    stack_top = 11'h5A3;
    issue(12'h01F);
    @(negedge clk);
    instr = 12'hC77;
    chk({pc_load, stack_pop, instr_ready, global_irq_enable, pc_value}, {4'b1101, 11'h5A3});
    @(negedge clk);
    instr_valid = 1'b0;
    chk({retire, accum}, {1'b1, 8'h3C});
    irq_taken = 1'b1;
    @(negedge clk);
    irq_taken = 1'b0;
    stack_top = 11'h123;
    run(12'h8C3);
    chk({pc_load, stack_pop, global_irq_enable, accum, pc_value}, {3'b110, 8'hC3, 11'h123});
    @(negedge clk);
    chk(retire, 1'b1);
    $display("Test returns done");
  endtask
  task automatic t_illegal_irq();
    run(12'h900);
    chk({illegal_op, pc_advance, retire, file_we, accum}, {4'b1110, 8'hC3});
    // An interrupt entry in the same cycle as a return from interrupt: the set wins.
    @(negedge clk);
    irq_taken = 1'b1;
    instr_valid = 1'b1;
    instr = 12'h01F;
    @(negedge clk);
    irq_taken = 1'b0;
    instr_valid = 1'b0;
    chk({pc_load, global_irq_enable}, 2'b11);
    @(negedge clk);
    chk({retire, global_irq_enable}, 2'b11);
    $display("Test illegal and irq race done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 32; i++) fr[i] = 8'h00;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_or_lit();
    t_store_copy();
    t_bank_option_idle();
    t_returns();
    t_illegal_irq();
    tally_and_finish();
  end
  initial begin
    #20us;
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** mlr_checker.sv ***
// Port-level assertions of the move, logic and return unit, bound into its top module.
`default_nettype none
module mlr_checker (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                instr_valid,
  input wire logic                instr_ready,
  input wire mlr_pkg::mlr_instr_t instr,
  input wire mlr_pkg::mlr_data_t  file_rdata,
  input wire mlr_pkg::mlr_pc_t    stack_top,
  input wire logic                file_we,
  input wire mlr_pkg::mlr_faddr_t file_waddr,
  input wire mlr_pkg::mlr_data_t  file_wdata,
  input wire mlr_pkg::mlr_data_t  accum,
  input wire logic                zero_flag,
  input wire mlr_pkg::mlr_bank_t  bank_select_reg,
  input wire mlr_pkg::mlr_data_t  option_reg,
  input wire logic                global_irq_enable,
  input wire logic                pc_load,
  input wire mlr_pkg::mlr_pc_t    pc_value,
  input wire logic                stack_pop,
  input wire logic                pc_advance
);
  timeunit 1ns / 1ps;
  import mlr_pkg::*;
  logic      acc;
  logic      ret;
  mlr_data_t or_res;
  assign acc = instr_valid && instr_ready;
  assign ret = instr == 12'h01F || instr[11:8] == 4'h8;
  // Sampling the OR result through a plain net keeps $past on a single signal.
  assign or_res = accum | file_rdata;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  a_or_result: assert property (acc && instr[11:6] == 6'h04 |=> zero_flag == ($past(or_res) == 8'h00)
    && ($past(instr[5]) ? file_we && file_wdata == $past(or_res) : accum == $past(or_res)))
    else $error("OR result or zero flag wrong");
  a_store_file: assert property (acc && instr[11:5] == 7'h01 |=> file_we && file_waddr == $past(instr[4:0])
    && file_wdata == $past(accum) && $stable(zero_flag))
    else $error("store to file wrong");
  a_copy_zero: assert property (acc && instr[11:6] == 6'h08 |=> zero_flag == ($past(file_rdata) == 8'h00)
    && ($past(instr[5]) || accum == $past(file_rdata)))
    else $error("copy of file register wrong");
  a_bank_load: assert property (acc && instr[11:3] == 9'h002 |=> bank_select_reg == $past(instr[2:0]))
    else $error("bank select not loaded");
  a_option_load: assert property (acc && instr == 12'h002 |=> option_reg == $past(accum) && $stable(zero_flag))
    else $error("option register not loaded");
  a_literal_accum: assert property (acc && (instr[11:8] == 4'h8 || instr[11:8] == 4'hC)
    |=> accum == $past(instr[7:0]))
    else $error("literal not in accumulator");
  a_literal_flags: assert property (acc && instr[11:8] == 4'hC |=> $stable(zero_flag))
    else $error("literal load touched zero flag");
  a_irq_enable_set: assert property (acc && instr == 12'h01F |=> global_irq_enable)
    else $error("return from irq left enable low");
  a_return_timing: assert property (acc && ret |=> pc_load && stack_pop && !instr_ready && !pc_advance)
    else $error("return did not take two cycles");
  a_return_pc: assert property (acc && ret |=> pc_value == $past(stack_top))
    else $error("return did not load stack top");
  a_idle_still: assert property (acc && instr == 12'h000 |=> pc_advance && !file_we && $stable(accum))
    else $error("idle instruction changed state");
  c_return: cover property (acc && ret);
  c_or_file: cover property (acc && instr[11:5] == 7'h09);
  c_store: cover property (acc && instr[11:5] == 7'h01);
endmodule
//////////////////////////////////////////////////////////////////////////////
bind mlr_exec mlr_checker u_chk (
  .clk, .rst_n, .instr_valid, .instr_ready, .instr, .file_rdata, .stack_top, .file_we, .file_waddr,
  .file_wdata, .accum, .zero_flag, .bank_select_reg, .option_reg, .global_irq_enable, .pc_load,
  .pc_value, .stack_pop, .pc_advance
);
`default_nettype wire

// *** mlr_decode.sv ***
// Instruction word decoder of the move, logic and return unit.
`default_nettype none
`include "mlr_map.svh"
module mlr_decode (
  input  wire mlr_pkg::mlr_instr_t instr,
  output mlr_pkg::mlr_dec_t        dec
);
  import mlr_pkg::*;

  always_comb begin
    dec       = '0;
    dec.dest  = instr[`MLR_DEST_BIT];
    dec.faddr = instr[`MLR_FADDR_LSB +: 5];
    dec.lit   = instr[`MLR_LIT_LSB +: 8];
    dec.bank  = instr[`MLR_BANK_LSB +: 3];
    // Exact patterns are tested first so that wider masks cannot shadow them.
    if ((instr & `MLR_MSK_IDLE) == `MLR_OPC_IDLE) begin
      dec.op = MLR_OP_IDLE;
    end else if ((instr & `MLR_MSK_OPTION) == `MLR_OPC_OPTION) begin
      dec.op = MLR_OP_OPTION;
    end else if ((instr & `MLR_MSK_RET_IRQ) == `MLR_OPC_RET_IRQ) begin
      dec.op = MLR_OP_RETIRQ;
    end else if ((instr & `MLR_MSK_BANK) == `MLR_OPC_BANK) begin
      dec.op = MLR_OP_BANK;
    end else if ((instr & `MLR_MSK_STORE) == `MLR_OPC_STORE) begin
      dec.op = MLR_OP_STORE;
    end else if ((instr & `MLR_MSK_OR_FILE) == `MLR_OPC_OR_FILE) begin
      dec.op = MLR_OP_OR_FILE;
    end else if ((instr & `MLR_MSK_COPY) == `MLR_OPC_COPY) begin
      dec.op = MLR_OP_COPY;
    end else if ((instr & `MLR_MSK_RET_LIT) == `MLR_OPC_RET_LIT) begin
      dec.op = MLR_OP_RETLIT;
    end else if ((instr & `MLR_MSK_LIT) == `MLR_OPC_LIT) begin
      dec.op = MLR_OP_LIT;
    end else begin
      dec.op = MLR_OP_ILLEGAL;
    end
  end

endmodule
`default_nettype wire

// *** mlr_exec.sv ***
// Execution of the move, logic and return instructions of the 8-bit core.
`default_nettype none
`include "mlr_map.svh"
module mlr_exec #(
  parameter int DATA_W  = 8,
  parameter int FADDR_W = 5,
  parameter int PC_W    = 11
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                instr_valid,
  output logic                     instr_ready,
  input  wire mlr_pkg::mlr_instr_t instr,
  output mlr_pkg::mlr_faddr_t      file_raddr,
  input  wire mlr_pkg::mlr_data_t  file_rdata,
  input  wire mlr_pkg::mlr_pc_t    stack_top,
  input  wire logic                irq_taken,
  output logic                     file_we,
  output mlr_pkg::mlr_faddr_t      file_waddr,
  output mlr_pkg::mlr_data_t       file_wdata,
  output mlr_pkg::mlr_data_t       accum,
  output logic                     zero_flag,
  output mlr_pkg::mlr_bank_t       bank_select_reg,
  output mlr_pkg::mlr_data_t       option_reg,
  output logic                     global_irq_enable,
  output logic                     pc_load,
  output mlr_pkg::mlr_pc_t         pc_value,
  output logic                     stack_pop,
  output logic                     pc_advance,
  output logic                     retire,
  output logic                     illegal_op
);
  import mlr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // The types fix the widths, so other parameter values are refused.

  if (DATA_W != 8) begin : g_data_w_check
    $error("mlr_exec supports only DATA_W=8.");
  end
  if (FADDR_W != 5) begin : g_faddr_w_check
    $error("mlr_exec supports only FADDR_W=5.");
  end
  if (PC_W != 11) begin : g_pc_w_check
    $error("mlr_exec supports only PC_W=11.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  // Assertion is immediate, release follows the clock, so no flop leaves reset near an edge.

  logic [1:0] rst_sync_reg;
  logic       rst_core_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_core_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  mlr_dec_t   dec;
  mlr_state_t st_reg;
  mlr_state_t st_next;
  mlr_data_t  result;
  logic       accept;

  mlr_decode u_decode (
    .instr (instr),
    .dec   (dec)
  );

  assign file_raddr  = dec.faddr;
  // Ready stays low until the internal reset copy is released, so no word is lost in reset.
  assign instr_ready = rst_core_n && (st_reg.fsm == MLR_ST_READY);
  assign accept      = instr_valid && instr_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    st_next            = st_reg;
    st_next.file_we    = 1'b0;
    st_next.pc_load    = 1'b0;
    st_next.stack_pop  = 1'b0;
    st_next.pc_advance = 1'b0;
    st_next.retire     = 1'b0;
    st_next.illegal    = 1'b0;
    result             = file_rdata;
    // An interrupt entry clears the enable, but a return from interrupt in the same cycle sets it again.
    if (irq_taken) begin
      st_next.irq_en = `MLR_RST_IRQ_EN;
    end
    unique case (st_reg.fsm)
      MLR_ST_READY: begin
        if (accept) begin
          st_next.retire     = 1'b1;
          st_next.pc_advance = 1'b1;
          unique case (dec.op)
            MLR_OP_OR_FILE,
            MLR_OP_COPY: begin
              if (dec.op == MLR_OP_OR_FILE) begin
                result = st_reg.accum | file_rdata;
              end else begin
                result = file_rdata;
              end
              st_next.zero = (result == 8'h00);
              // The write-back of an unchanged value is kept so the file sees the access.
              if (dec.dest == `MLR_DEST_FILE) begin
                st_next.file_we    = 1'b1;
                st_next.file_waddr = dec.faddr;
                st_next.file_wdata = result;
              end else begin
                st_next.accum = result;
              end
            end
            MLR_OP_STORE: begin
              st_next.file_we    = 1'b1;
              st_next.file_waddr = dec.faddr;
              st_next.file_wdata = st_reg.accum;
            end
            MLR_OP_BANK: begin
              st_next.bank = dec.bank;
            end
            MLR_OP_OPTION: begin
              st_next.option = st_reg.accum;
            end
            MLR_OP_LIT: begin
              st_next.accum = dec.lit;
            end
            MLR_OP_RETIRQ,
            MLR_OP_RETLIT: begin
              // The second instruction cycle is spent in the return state.
              st_next.retire     = 1'b0;
              st_next.pc_advance = 1'b0;
              st_next.fsm        = MLR_ST_RETURN;
              st_next.pc_load    = 1'b1;
              st_next.pc_value   = stack_top;
              st_next.stack_pop  = 1'b1;
              if (dec.op == MLR_OP_RETIRQ) begin
                st_next.irq_en = `MLR_IRQ_EN_ON;
              end else begin
                st_next.accum = dec.lit;
              end
            end
            MLR_OP_IDLE: begin
              st_next.pc_advance = 1'b1;
            end
            MLR_OP_ILLEGAL: begin
              // Foreign opcodes belong to other units; here the marker is raised beside retire and pc_advance, and no other state changes.
              st_next.illegal = 1'b1;
            end
          endcase
        end
      end
      MLR_ST_RETURN: begin
        // Ready is low in this cycle, so a word offered now is refused, not consumed.
        st_next.fsm    = MLR_ST_READY;
        st_next.retire = 1'b1;
      end
      default: begin
        st_next.fsm = MLR_ST_READY;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      st_reg            <= '0;
      st_reg.fsm        <= MLR_ST_READY;
      st_reg.accum      <= `MLR_RST_ACCUM;
      st_reg.zero       <= `MLR_RST_ZERO;
      st_reg.bank       <= `MLR_RST_BANK;
      st_reg.option     <= `MLR_RST_OPTION;
      st_reg.irq_en     <= `MLR_RST_IRQ_EN;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign file_we           = st_reg.file_we;
  assign file_waddr        = st_reg.file_waddr;
  assign file_wdata        = st_reg.file_wdata;
  assign accum             = st_reg.accum;
  assign zero_flag         = st_reg.zero;
  assign bank_select_reg   = st_reg.bank;
  assign option_reg        = st_reg.option;
  assign global_irq_enable = st_reg.irq_en;
  assign pc_load           = st_reg.pc_load;
  assign pc_value          = st_reg.pc_value;
  assign stack_pop         = st_reg.stack_pop;
  assign pc_advance        = st_reg.pc_advance;
  assign retire            = st_reg.retire;
  assign illegal_op        = st_reg.illegal;

endmodule
`default_nettype wire

// *** mlr_map.svh ***
// Opcode patterns, field positions, reset values and cycle counts of the move, logic and return unit.
`ifndef MLR_MAP_SVH
`define MLR_MAP_SVH

`define MLR_OPC_IDLE       12'h000
`define MLR_MSK_IDLE       12'hFFF
`define MLR_OPC_OPTION     12'h002
`define MLR_MSK_OPTION     12'hFFF
`define MLR_OPC_RET_IRQ    12'h01F
`define MLR_MSK_RET_IRQ    12'hFFF
`define MLR_OPC_BANK       12'h010
`define MLR_MSK_BANK       12'hFF8
`define MLR_OPC_STORE      12'h020
`define MLR_MSK_STORE      12'hFE0
`define MLR_OPC_OR_FILE    12'h100
`define MLR_MSK_OR_FILE    12'hFC0
`define MLR_OPC_COPY       12'h200
`define MLR_MSK_COPY       12'hFC0
`define MLR_OPC_RET_LIT    12'h800
`define MLR_MSK_RET_LIT    12'hF00
`define MLR_OPC_LIT        12'hC00
`define MLR_MSK_LIT        12'hF00

`define MLR_DEST_BIT       5
`define MLR_DEST_ACCUM     1'b0
`define MLR_DEST_FILE      1'b1
`define MLR_FADDR_LSB      0
`define MLR_LIT_LSB        0
`define MLR_BANK_LSB       0

`define MLR_RST_ACCUM      8'h00
`define MLR_RST_OPTION     8'hFF
`define MLR_RST_BANK       3'h0
`define MLR_RST_ZERO       1'b0
`define MLR_RST_IRQ_EN     1'b0
`define MLR_IRQ_EN_ON      1'b1

`define MLR_RET_CYCLES     2

`endif

// *** mlr_pkg.sv ***
// Types shared by the move, logic and return unit.
`default_nettype none
package mlr_pkg;

  typedef logic [11:0] mlr_instr_t;
  typedef logic [7:0]  mlr_data_t;
  typedef logic [4:0]  mlr_faddr_t;
  typedef logic [2:0]  mlr_bank_t;
  typedef logic [10:0] mlr_pc_t;

  typedef enum logic [3:0] {
    MLR_OP_IDLE    = 4'h0,
    MLR_OP_OR_FILE = 4'h1,
    MLR_OP_STORE   = 4'h2,
    MLR_OP_COPY    = 4'h3,
    MLR_OP_BANK    = 4'h4,
    MLR_OP_OPTION  = 4'h5,
    MLR_OP_LIT     = 4'h6,
    MLR_OP_RETIRQ  = 4'h7,
    MLR_OP_RETLIT  = 4'h8,
    MLR_OP_ILLEGAL = 4'h9
  } mlr_op_t;

  typedef struct packed {
    mlr_op_t    op;
    logic       dest;
    mlr_faddr_t faddr;
    mlr_data_t  lit;
    mlr_bank_t  bank;
  } mlr_dec_t;

  typedef enum logic [1:0] {
    MLR_ST_READY  = 2'b01,
    MLR_ST_RETURN = 2'b10
  } mlr_fsm_t;

  typedef struct packed {
    mlr_fsm_t   fsm;
    mlr_data_t  accum;
    logic       zero;
    mlr_bank_t  bank;
    mlr_data_t  option;
    logic       irq_en;
    logic       file_we;
    mlr_faddr_t file_waddr;
    mlr_data_t  file_wdata;
    logic       pc_load;
    mlr_pc_t    pc_value;
    logic       stack_pop;
    logic       pc_advance;
    logic       retire;
    logic       illegal;
  } mlr_state_t;

endpackage
`default_nettype wire
